// *** verif/cpu_special_register_set_tb.sv ***
// Self-checking bench: register moves, pipeline, translation and ALU strobes.
// Assumes the design and the adder partner model are compiled before it.
`timescale 1ns/1ps
`define CHK(GOT, EXP) begin compares++; if ((GOT) !== (EXP)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, GOT, EXP); end end
module cpu_special_register_set_tb;
  integer      seed = 32'h269a376d, err_count = 0, compares = 0, i, j;
  logic        clk = 1'b0, reset, sr_wr_en, sr_rd_en, wb_valid, pipeline_freeze, xlat_lookup, user_mode;
  logic        tlb_miss, prot_violation, sel_valid, muldiv_load, alu_arith, alu_signed, df_set_one;
  logic        df_set_from_alu, alu_bit33, ls_valid, load_sets_byte_ptr, byte_lane_mode, endian_select;
  logic        ext_valid, ext_half, ext_sign, fsh_valid, op_go, op_use_c;
  logic        tag_match, divide_add, alu_carry_in, alu_update, alu_carry_out, alu_carry_into_msb;
  logic [1:0]  ls_addr_low, page_size_sel, byte_selector;
  logic [2:0]  reg_num_absolute;
  logic [3:0]  page_offset_bits;
  logic [4:0]  shift_amount;
  logic [5:0]  replace_entry_hint;
  logic [7:0]  sr_wr_num, sr_rd_num, entry_task_tag, a_selector_field, b_selector_field, c_selector_field;
  logic [7:0]  a_reg_num, b_reg_num, c_reg_num, tag;
  logic [31:0] sr_wr_data, sr_rd_data, wb_pc, muldiv_data, muldiv_word, alu_result, ext_word, ext_result;
  logic [31:0] fsh_src_hi, fsh_src_lo, fsh_result, op_a, op_b, d, e;
  logic [32:0] s;
  logic [31:0] m [256];
  logic [7:0]  nums [11] = '{8'h0c, 8'h0d, 8'h0e, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h20};

  always #5 clk = ~clk;
  csr_special_regs dut (.*);
  csr_alu_model alu (.*);

  task tick;
    @(negedge clk);
  endtask : tick

  // Mirror keeps only what a read returns; ignored numbers fall to default
  task automatic wr(input logic [7:0] n, input logic [31:0] v);
    sr_wr_en = 1'b1;
    sr_wr_num = n;
    sr_wr_data = v;
    tick();
    sr_wr_en = 1'b0;
    case (n)
      8'h0d: m[n] = v & 32'h0000_03ff;
      8'h80, 8'h81, 8'h82: m[n] = v & 32'h0000_03fc;
      8'h83: m[n] = v;
      8'h84: m[n] = v & 32'h0000_0fff;
      8'h85: m[8'h84] = m[8'h84] & 32'hffff_ff9f | (v & 32'h3) << 5;
      8'h86: m[8'h84] = m[8'h84] & 32'hffff_ffe0 | v & 32'h1f;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] n);
    sr_rd_en = 1'b1;
    sr_rd_num = n;
    tick();
    sr_rd_en = 1'b0;
    e = n == 8'h85 ? m[8'h84] >> 5 & 32'h3 : n == 8'h86 ? m[8'h84] & 32'h1f : m[n];
    `CHK(sr_rd_data, e)
    // Idle cycle, so back-to-back reads never drop and raise the strobe at once
    tick();
  endtask : rd

  task tally_and_finish;
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    {sr_wr_en, sr_rd_en, wb_valid, pipeline_freeze, xlat_lookup, user_mode, tlb_miss, prot_violation,
     sel_valid, muldiv_load, alu_arith, alu_signed, df_set_one, df_set_from_alu, alu_bit33, ls_valid,
     load_sets_byte_ptr, byte_lane_mode, endian_select, ext_valid, ext_half, ext_sign, fsh_valid, op_go,
     op_use_c, ls_addr_low, replace_entry_hint, sr_wr_num, sr_rd_num, entry_task_tag, a_selector_field,
     b_selector_field, c_selector_field, sr_wr_data, wb_pc, muldiv_data, ext_word, fsh_src_hi, fsh_src_lo,
     op_a, op_b} = '0;
    reset = 1'b1;
    for (i = 0; i < 256; i++) m[i] = '0;
    repeat (8) tick();
    reset = 1'b0;
    `CHK(page_offset_bits, 4'ha)
    for (i = 0; i < 11; i++) rd(nums[i]);
    for (i = 0; i < 33; i++) begin
      wr(nums[i % 11], $random(seed));
      rd(nums[i % 11]);
    end
    for (i = 0; i < 4; i++) begin
      wb_pc = $random(seed);
      pipeline_freeze = i[0];
      wb_valid = 1'b1;
      tick();
      wb_valid = 1'b0;
      if (!i[0]) m[8'h0c] = wb_pc & 32'hffff_fffc;
      rd(8'h0c);
    end
    for (i = 0; i < 2; i++) begin
      replace_entry_hint = 6'($random(seed));
      {tlb_miss, prot_violation} = i[0] ? 2'b01 : 2'b10;
      tick();
      {tlb_miss, prot_violation} = 2'b00;
      m[8'h0e] = 32'(replace_entry_hint) << 1;
      rd(8'h0e);
    end
    // Lookups stay two cycles clear of the size write, as the pipeline must
    tag = 8'($random(seed)) | 8'h01;
    for (i = 0; i < 4; i++) begin
      wr(8'h0d, {22'h0, i[1:0], tag});
      repeat (2) tick();
      `CHK(page_size_sel, i[1:0])
      `CHK(page_offset_bits, 4'ha + i[1:0])
      user_mode = i < 2;
      entry_task_tag = i[0] ? (i < 2 ? tag ^ 8'h01 : tag) : (i < 2 ? tag : 8'h00);
      xlat_lookup = 1'b1;
      tick();
      xlat_lookup = 1'b0;
      `CHK(tag_match, !i[0])
    end
    for (i = 0; i < 12; i++) begin
      op_a = $random(seed);
      op_b = i == 0 ? -op_a : $random(seed);
      op_use_c = i[1];
      {alu_arith, alu_signed} = 2'($random(seed));
      d = m[8'h84];
      s = {1'b0, op_a} + {1'b0, op_b} + 33'(op_use_c & d[7]);
      e = {1'b0, op_a[30:0]} + {1'b0, op_b[30:0]} + 32'(op_use_c & d[7]);
      d[9] = s[31];
      d[8] = s[31:0] == 32'h0;
      if (alu_arith) d[7] = s[32];
      if (alu_signed) d[10] = s[32] ^ e[31];
      op_go = 1'b1;
      tick();
      op_go = 1'b0;
      m[8'h84] = d;
      rd(8'h84);
    end
    for (i = 0; i < 3; i++) begin
      df_set_one = i == 0;
      df_set_from_alu = i != 0;
      alu_bit33 = i == 1;
      tick();
      {df_set_one, df_set_from_alu} = 2'b00;
      m[8'h84][11] = i != 1;
      `CHK(divide_add, i != 1)
      tick();
    end
    muldiv_data = $random(seed);
    muldiv_load = 1'b1;
    tick();
    muldiv_load = 1'b0;
    m[8'h83] = muldiv_data;
    `CHK(muldiv_word, muldiv_data)
    rd(8'h83);
    for (i = 0; i < 8; i++) begin
      {byte_lane_mode, endian_select} = i[1:0];
      ls_addr_low = 2'($random(seed));
      load_sets_byte_ptr = !i[2];
      ls_valid = 1'b1;
      tick();
      ls_valid = 1'b0;
      if (!i[2]) m[8'h84][6:5] = byte_lane_mode ? {2{!endian_select}} : ls_addr_low;
      `CHK(byte_selector, m[8'h84][6:5])
      d = m[8'h84];
      ext_word = $random(seed);
      {ext_half, ext_sign} = 2'($random(seed));
      j = ext_half ? 16 * (d[6] ^ endian_select) : 8 * (d[6:5] ^ {2{endian_select}});
      e = ext_word >> j;
      // Only half-words are sign extended; bytes come back zero extended
      e = ext_half ? {{16{ext_sign & e[15]}}, e[15:0]} : {24'h00_0000, e[7:0]};
      ext_valid = 1'b1;
      tick();
      ext_valid = 1'b0;
      `CHK(ext_result, e)
    end
    for (i = 0; i < 3; i++) begin
      wr(8'h86, i == 0 ? 0 : i == 1 ? 31 : $random(seed));
      fsh_src_hi = $random(seed);
      fsh_src_lo = $random(seed);
      fsh_valid = 1'b1;
      tick();
      fsh_valid = 1'b0;
      {e, d} = {fsh_src_hi, fsh_src_lo} << m[8'h84][4:0];
      `CHK(fsh_result, e)
      `CHK(shift_amount, m[8'h84][4:0])
    end
    rd(8'h84);
    for (i = 0; i < 2; i++) begin
      {a_selector_field, b_selector_field, c_selector_field} = i ? {3{8'($random(seed)) | 8'h01}} : 24'h0;
      sel_valid = 1'b1;
      tick();
      sel_valid = 1'b0;
      `CHK(reg_num_absolute, i ? 3'h0 : 3'h7)
      e = i ? {8'h00, a_selector_field, b_selector_field, c_selector_field}
            : {8'h00, m[8'h81][9:2], m[8'h82][9:2], m[8'h80][9:2]};
      `CHK(({8'h00, a_reg_num, b_reg_num, c_reg_num}), e)
      tick();
    end
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule : cpu_special_register_set_tb

// *** verif/csr_alu_model.sv ***
// Partner model: the adder of the arithmetic unit that feeds the flags.
// Assumes the bench supplies operands and the go strobe at the falling edge.
`timescale 1ns/1ps
module csr_alu_model (
  input  wire logic        op_go,
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic        op_use_c,
  input  wire logic        alu_carry_in,
  output logic             alu_update,
  output logic      [31:0] alu_result,
  output logic             alu_carry_out,
  output logic             alu_carry_into_msb
);
  logic        cin;
  logic [31:0] low;
  // Only add/subtract-with-carry consume the stored carry
  assign cin = op_use_c & alu_carry_in;
  assign alu_update = op_go;
  assign {alu_carry_out, alu_result} = {1'b0, op_a} + {1'b0, op_b} + 33'(cin);
  assign low = {1'b0, op_a[30:0]} + {1'b0, op_b[30:0]} + 32'(cin);
  assign alu_carry_into_msb = low[31];
endmodule : csr_alu_model

// *** verif/csr_special_regs_properties.sv ***
// Checker: strobes of the special register group against its outputs.
// Assumes it is bound to csr_special_regs and sees only its ports.
`timescale 1ns/1ps
module csr_special_regs_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [1:0]  page_size_sel,
  input wire logic [3:0]  page_offset_bits,
  input wire logic        xlat_lookup,
  input wire logic        user_mode,
  input wire logic [7:0]  entry_task_tag,
  input wire logic        tag_match,
  input wire logic        sel_valid,
  input wire logic [7:0]  a_selector_field,
  input wire logic [7:0]  b_selector_field,
  input wire logic [7:0]  c_selector_field,
  input wire logic [2:0]  reg_num_absolute,
  input wire logic        muldiv_load,
  input wire logic [31:0] muldiv_data,
  input wire logic [31:0] muldiv_word,
  input wire logic        df_set_one,
  input wire logic        df_set_from_alu,
  input wire logic        alu_bit33,
  input wire logic        divide_add,
  input wire logic        alu_update,
  input wire logic        alu_arith,
  input wire logic        alu_carry_out,
  input wire logic        alu_carry_in,
  input wire logic        ls_valid,
  input wire logic        load_sets_byte_ptr,
  input wire logic        byte_lane_mode,
  input wire logic [1:0]  ls_addr_low,
  input wire logic [1:0]  byte_selector,
  input wire logic        fsh_valid,
  input wire logic [31:0] fsh_src_hi,
  input wire logic [31:0] fsh_src_lo,
  input wire logic [4:0]  shift_amount,
  input wire logic [31:0] fsh_result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [63:0] fsh_cat;
  logic [31:0] fsh_exp;
  assign fsh_cat = {fsh_src_hi, fsh_src_lo} << shift_amount;
  assign fsh_exp = fsh_cat[63:32];
  sequence s_super_lookup;
    xlat_lookup && !user_mode;
  endsequence
  sequence s_df_from_alu;
    df_set_from_alu && !df_set_one;
  endsequence
  // Width and selector are registered together from the stored size; only settled values are compared
  a_page_offset_width: assert property ($stable(page_size_sel) |-> page_offset_bits == 4'ha + page_size_sel)
    else $error("page offset width disagrees with page size");
  a_super_tag_zero: assert property (s_super_lookup |=> tag_match == ($past(entry_task_tag) == 8'h00))
    else $error("supervisor lookup not compared with tag zero");
  a_no_lookup_idle: assert property (!xlat_lookup |=> !tag_match)
    else $error("tag match without lookup");
  a_operand_absolute: assert property (sel_valid |=> reg_num_absolute ==
    {$past(c_selector_field) == 8'h00, $past(b_selector_field) == 8'h00, $past(a_selector_field) == 8'h00})
    else $error("pointer use does not follow zero selectors");
  a_muldiv_capture: assert property (muldiv_load |=> muldiv_word == $past(muldiv_data))
    else $error("working word not loaded by unit");
  a_divide_set_one: assert property (df_set_one |=> divide_add)
    else $error("divide flag not forced to one");
  a_divide_from_alu: assert property (s_df_from_alu |=> divide_add == !$past(alu_bit33))
    else $error("divide flag not inverse of alu bit");
  a_carry_capture: assert property (alu_update && alu_arith |=> alu_carry_in == $past(alu_carry_out))
    else $error("carry flag not captured");
  a_byte_ptr_addr: assert property (ls_valid && load_sets_byte_ptr && !byte_lane_mode
    |=> byte_selector == $past(ls_addr_low))
    else $error("byte selector not taken from address");
  a_funnel_extract: assert property (fsh_valid |=> fsh_result == $past(fsh_exp))
    else $error("funnel result wrong");
endmodule : csr_special_regs_checker

bind csr_special_regs csr_special_regs_checker u_chk (.*);

// *** verilog/csr_byte_sel.sv ***
// Byte and half-word extract for the insert/extract instructions.
// Assumes endian_select is 1 for most-significant-byte-first order.
`timescale 1ns/1ps
module csr_byte_sel (
  input  wire logic [31:0] word_in,
  input  wire logic [1:0]  byte_selector,
  input  wire logic        endian_select,
  input  wire logic        half_mode,
  input  wire logic        sign_ext,
  output logic      [31:0] result
);
  logic [1:0] lane;
  logic [7:0] byte_v;
  logic [15:0] half_v;
  logic       half_lo;

  always_comb begin
    // Big-endian order counts lanes from the top of the word
    lane    = endian_select ? ~byte_selector : byte_selector;
    half_lo = endian_select ? ~byte_selector[1] : byte_selector[1];
    byte_v  = word_in[8*lane +: 8];
    half_v  = half_lo ? word_in[31:16] : word_in[15:0];
    if (half_mode) begin
      result = {{16{sign_ext & half_v[15]}}, half_v};
    end else begin
      result = {24'h00_0000, byte_v};
    end
  end
endmodule : csr_byte_sel

// *** verilog/csr_funnel.sv ***
// Funnel shifter: 32 bits taken from a 64-bit concatenation.
// Assumes the count comes from the shift_amount field.
`timescale 1ns/1ps
module csr_funnel (
  input  wire logic [31:0] src_hi,
  input  wire logic [31:0] src_lo,
  input  wire logic [4:0]  shift_amount,
  output logic      [31:0] result
);
  logic [63:0] joined;

  always_comb begin
    joined = {src_hi, src_lo} << shift_amount;
    result = joined[63:32];
  end
endmodule : csr_funnel

// *** verilog/csr_pkg.sv ***
// Constants for the special register group: register numbers, field
// positions and values after reset.
// Assumes an 8-bit special register number on the move port.
package csr_pkg;

  // Special register numbers on the move port
  localparam logic [7:0] REG_WB_ADDR    = 8'h0c;
  localparam logic [7:0] REG_XLAT_CFG   = 8'h0d;
  localparam logic [7:0] REG_REPL_HINT  = 8'h0e;
  localparam logic [7:0] REG_IND_C      = 8'h80;
  localparam logic [7:0] REG_IND_A      = 8'h81;
  localparam logic [7:0] REG_IND_B      = 8'h82;
  localparam logic [7:0] REG_MULDIV     = 8'h83;
  localparam logic [7:0] REG_ARITH      = 8'h84;
  localparam logic [7:0] REG_BP_ALIAS   = 8'h85;
  localparam logic [7:0] REG_FC_ALIAS   = 8'h86;

  // Field positions
  localparam int WB_ADDR_LSB   = 2;
  localparam int PS_LSB        = 8;
  localparam int PTAG_LSB      = 0;
  localparam int HINT_LSB      = 1;
  localparam int PTR_LSB       = 2;
  localparam int DF_BIT        = 11;
  localparam int V_BIT         = 10;
  localparam int N_BIT         = 9;
  localparam int Z_BIT         = 8;
  localparam int C_BIT         = 7;
  localparam int BP_LSB        = 5;
  localparam int FC_LSB        = 0;

  // Page size codes and base offset width
  localparam logic [1:0] PS_1KB        = 2'h0;
  localparam logic [1:0] PS_2KB        = 2'h1;
  localparam logic [1:0] PS_4KB        = 2'h2;
  localparam logic [1:0] PS_8KB        = 2'h3;
  localparam logic [3:0] PAGE_BITS_MIN = 4'ha;
  localparam logic [7:0] SUPER_TAG     = 8'h00;

  // Values after reset
  localparam logic [29:0] RST_WB_ADDR  = 30'h0000_0000;
  localparam logic [1:0]  RST_PS       = 2'h0;
  localparam logic [7:0]  RST_PTAG     = 8'h00;
  localparam logic [5:0]  RST_HINT     = 6'h00;
  localparam logic [7:0]  RST_PTR      = 8'h00;
  localparam logic [31:0] RST_MULDIV   = 32'h0000_0000;
  localparam logic [1:0]  RST_BP       = 2'h0;
  localparam logic [4:0]  RST_FC       = 5'h00;
  localparam logic        RST_FLAG     = 1'b0;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

endpackage : csr_pkg

// *** verilog/csr_special_regs.sv ***
// Special register group of the processor: write-back address, translation
// configuration, replacement hint, indirect pointers, multiply/divide word
// and arithmetic status with its byte-pointer and shift-count views.
// Assumes pipeline, translation and ALU strobes are synchronous to clk.
`timescale 1ns/1ps

module csr_special_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  // Move-to/from special register port
  input  wire logic        sr_wr_en,
  input  wire logic [7:0]  sr_wr_num,
  input  wire logic [31:0] sr_wr_data,
  input  wire logic        sr_rd_en,
  input  wire logic [7:0]  sr_rd_num,
  output logic      [31:0] sr_rd_data,
  // Pipeline
  input  wire logic        wb_valid,
  input  wire logic [31:0] wb_pc,
  input  wire logic        pipeline_freeze,
  // Translation unit
  input  wire logic        xlat_lookup,
  input  wire logic        user_mode,
  input  wire logic [7:0]  entry_task_tag,
  input  wire logic        tlb_miss,
  input  wire logic        prot_violation,
  input  wire logic [5:0]  replace_entry_hint,
  output logic      [1:0]  page_size_sel,
  output logic      [3:0]  page_offset_bits,
  output logic             tag_match,
  // Operand selection
  input  wire logic        sel_valid,
  input  wire logic [7:0]  a_selector_field,
  input  wire logic [7:0]  b_selector_field,
  input  wire logic [7:0]  c_selector_field,
  output logic      [7:0]  a_reg_num,
  output logic      [7:0]  b_reg_num,
  output logic      [7:0]  c_reg_num,
  output logic      [2:0]  reg_num_absolute,
  // Multiply/divide unit
  input  wire logic        muldiv_load,
  input  wire logic [31:0] muldiv_data,
  output logic      [31:0] muldiv_word,
  // ALU
  input  wire logic        alu_update,
  input  wire logic        alu_arith,
  input  wire logic        alu_signed,
  input  wire logic [31:0] alu_result,
  input  wire logic        alu_carry_out,
  input  wire logic        alu_carry_into_msb,
  input  wire logic        df_set_one,
  input  wire logic        df_set_from_alu,
  input  wire logic        alu_bit33,
  output logic             divide_add,
  output logic             alu_carry_in,
  // Load/store byte pointer
  input  wire logic        ls_valid,
  input  wire logic        load_sets_byte_ptr,
  input  wire logic [1:0]  ls_addr_low,
  input  wire logic        byte_lane_mode,
  input  wire logic        endian_select,
  // Byte/half-word extract and funnel shift
  input  wire logic        ext_valid,
  input  wire logic [31:0] ext_word,
  input  wire logic        ext_half,
  input  wire logic        ext_sign,
  output logic      [31:0] ext_result,
  input  wire logic        fsh_valid,
  input  wire logic [31:0] fsh_src_hi,
  input  wire logic [31:0] fsh_src_lo,
  output logic      [31:0] fsh_result,
  output logic      [1:0]  byte_selector,
  output logic      [4:0]  shift_amount
);

  logic [29:0] wb_addr_q;
  logic [1:0]  ps_q;
  logic [7:0]  ptag_q;
  logic [5:0]  hint_q;
  logic [7:0]  ptr_c_q;
  logic [7:0]  ptr_a_q;
  logic [7:0]  ptr_b_q;
  logic [31:0] muldiv_q;
  logic        df_q;
  logic        v_q;
  logic        n_q;
  logic        z_q;
  logic        c_q;
  logic [1:0]  bp_q;
  logic [4:0]  fc_q;
  logic [31:0] rd_data_q;
  logic        tag_match_q;
  logic [7:0]  a_num_q;
  logic [7:0]  b_num_q;
  logic [7:0]  c_num_q;
  logic [2:0]  abs_q;
  logic [31:0] ext_q;
  logic [31:0] fsh_q;
  logic [31:0] ext_comb;
  logic [31:0] fsh_comb;
  logic [7:0]  eff_tag;

  wire wr_cfg   = sr_wr_en && (sr_wr_num == csr_pkg::REG_XLAT_CFG);
  wire wr_ind_c = sr_wr_en && (sr_wr_num == csr_pkg::REG_IND_C);
  wire wr_ind_a = sr_wr_en && (sr_wr_num == csr_pkg::REG_IND_A);
  wire wr_ind_b = sr_wr_en && (sr_wr_num == csr_pkg::REG_IND_B);
  wire wr_mdw   = sr_wr_en && (sr_wr_num == csr_pkg::REG_MULDIV);
  wire wr_arith = sr_wr_en && (sr_wr_num == csr_pkg::REG_ARITH);
  wire wr_bp    = sr_wr_en && (sr_wr_num == csr_pkg::REG_BP_ALIAS);
  wire wr_fc    = sr_wr_en && (sr_wr_num == csr_pkg::REG_FC_ALIAS);

  // Write-back stage address; only bits 31-2 are stored
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_addr_q <= csr_pkg::RST_WB_ADDR;
    end else if (wb_valid && !pipeline_freeze) begin
      wb_addr_q <= wb_pc[31:csr_pkg::WB_ADDR_LSB];
    end
  end

  // Translation configuration; only defined bits are stored
  always_ff @(posedge clk) begin
    if (reset) begin
      ps_q   <= csr_pkg::RST_PS;
      ptag_q <= csr_pkg::RST_PTAG;
    end else if (wr_cfg) begin
      ps_q   <= sr_wr_data[csr_pkg::PS_LSB +: 2];
      ptag_q <= sr_wr_data[csr_pkg::PTAG_LSB +: 8];
    end
  end

  // The registered size reaches the translator one cycle after the move,
  // which software must allow for before translating.
  always_ff @(posedge clk) begin
    if (reset) begin
      page_size_sel    <= csr_pkg::RST_PS;
      page_offset_bits <= csr_pkg::PAGE_BITS_MIN;
    end else begin
      page_size_sel    <= ps_q;
      page_offset_bits <= csr_pkg::PAGE_BITS_MIN + {2'h0, ps_q};
    end
  end

  // Supervisor accesses compare against tag zero
  always_comb begin
    eff_tag = user_mode ? ptag_q : csr_pkg::SUPER_TAG;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tag_match_q <= 1'b0;
    end else begin
      tag_match_q <= xlat_lookup && (eff_tag == entry_task_tag);
    end
  end

  // Hint is loaded on a miss and on a protection violation alike; in the
  // latter case the value has no meaning but is still overwritten.
  always_ff @(posedge clk) begin
    if (reset) begin
      hint_q <= csr_pkg::RST_HINT;
    end else if (tlb_miss || prot_violation) begin
      hint_q <= replace_entry_hint;
    end
  end

  // Indirect pointers hold bits 9-2 only
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_c_q <= csr_pkg::RST_PTR;
      ptr_a_q <= csr_pkg::RST_PTR;
      ptr_b_q <= csr_pkg::RST_PTR;
    end else begin
      if (wr_ind_c) ptr_c_q <= sr_wr_data[csr_pkg::PTR_LSB +: 8];
      if (wr_ind_a) ptr_a_q <= sr_wr_data[csr_pkg::PTR_LSB +: 8];
      if (wr_ind_b) ptr_b_q <= sr_wr_data[csr_pkg::PTR_LSB +: 8];
    end
  end

  // Operand register numbers; absolute flags tell the file to skip the
  // stack-pointer addition for pointer-supplied numbers.
  always_ff @(posedge clk) begin
    if (reset) begin
      a_num_q <= 8'h00;
      b_num_q <= 8'h00;
      c_num_q <= 8'h00;
      abs_q   <= 3'h0;
    end else if (sel_valid) begin
      a_num_q  <= (a_selector_field == 8'h00) ? ptr_a_q : a_selector_field;
      b_num_q  <= (b_selector_field == 8'h00) ? ptr_b_q : b_selector_field;
      c_num_q  <= (c_selector_field == 8'h00) ? ptr_c_q : c_selector_field;
      abs_q[0] <= (a_selector_field == 8'h00);
      abs_q[1] <= (b_selector_field == 8'h00);
      abs_q[2] <= (c_selector_field == 8'h00);
    end
  end

  // Multiply/divide working word; the unit owns its meaning per step
  always_ff @(posedge clk) begin
    if (reset) begin
      muldiv_q <= csr_pkg::RST_MULDIV;
    end else if (muldiv_load) begin
      muldiv_q <= muldiv_data;
    end else if (wr_mdw) begin
      muldiv_q <= sr_wr_data;
    end
  end

  // Divide flag: hardware update takes priority over a move
  always_ff @(posedge clk) begin
    if (reset) begin
      df_q <= csr_pkg::RST_FLAG;
    end else if (df_set_one) begin
      df_q <= 1'b1;
    end else if (df_set_from_alu) begin
      df_q <= ~alu_bit33;
    end else if (wr_arith) begin
      df_q <= sr_wr_data[csr_pkg::DF_BIT];
    end
  end

  // Result flags
  always_ff @(posedge clk) begin
    if (reset) begin
      v_q <= csr_pkg::RST_FLAG;
      n_q <= csr_pkg::RST_FLAG;
      z_q <= csr_pkg::RST_FLAG;
    end else if (alu_update) begin
      if (alu_signed) begin
        v_q <= alu_carry_out ^ alu_carry_into_msb;
      end
      n_q <= alu_result[31];
      z_q <= (alu_result == csr_pkg::ZERO_WORD);
    end else if (wr_arith) begin
      v_q <= sr_wr_data[csr_pkg::V_BIT];
      n_q <= sr_wr_data[csr_pkg::N_BIT];
      z_q <= sr_wr_data[csr_pkg::Z_BIT];
    end
  end

  // Carry flag, only arithmetic operations and moves to REG_ARITH change it
  always_ff @(posedge clk) begin
    if (reset) begin
      c_q <= csr_pkg::RST_FLAG;
    end else if (alu_update && alu_arith) begin
      c_q <= alu_carry_out;
    end else if (wr_arith) begin
      c_q <= sr_wr_data[csr_pkg::C_BIT];
    end
  end

  // Byte selector: load/store update wins over a move in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      bp_q <= csr_pkg::RST_BP;
    end else if (ls_valid && load_sets_byte_ptr) begin
      bp_q <= byte_lane_mode ? {2{~endian_select}} : ls_addr_low;
    end else if (wr_arith) begin
      bp_q <= sr_wr_data[csr_pkg::BP_LSB +: 2];
    end else if (wr_bp) begin
      bp_q <= sr_wr_data[1:0];
    end
  end

  // Shift amount via either view
  always_ff @(posedge clk) begin
    if (reset) begin
      fc_q <= csr_pkg::RST_FC;
    end else if (wr_arith) begin
      fc_q <= sr_wr_data[csr_pkg::FC_LSB +: 5];
    end else if (wr_fc) begin
      fc_q <= sr_wr_data[4:0];
    end
  end

  csr_byte_sel u_byte_sel (
    .word_in       (ext_word),
    .byte_selector (bp_q),
    .endian_select (endian_select),
    .half_mode     (ext_half),
    .sign_ext      (ext_sign),
    .result        (ext_comb)
  );

  csr_funnel u_funnel (
    .src_hi       (fsh_src_hi),
    .src_lo       (fsh_src_lo),
    .shift_amount (fc_q),
    .result       (fsh_comb)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_q <= csr_pkg::ZERO_WORD;
      fsh_q <= csr_pkg::ZERO_WORD;
    end else begin
      if (ext_valid) begin
        ext_q <= ext_comb;
      end
      if (fsh_valid) begin
        fsh_q <= fsh_comb;
      end
    end
  end

  // Read path; unlisted numbers and reserved bits return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= csr_pkg::ZERO_WORD;
    end else if (sr_rd_en) begin
      case (sr_rd_num)
        csr_pkg::REG_WB_ADDR:   rd_data_q <= {wb_addr_q, 2'h0};
        csr_pkg::REG_XLAT_CFG:  rd_data_q <= {22'h00_0000, ps_q, ptag_q};
        csr_pkg::REG_REPL_HINT: rd_data_q <= {25'h000_0000, hint_q, 1'b0};
        csr_pkg::REG_IND_C:     rd_data_q <= {22'h00_0000, ptr_c_q, 2'h0};
        csr_pkg::REG_IND_A:     rd_data_q <= {22'h00_0000, ptr_a_q, 2'h0};
        csr_pkg::REG_IND_B:     rd_data_q <= {22'h00_0000, ptr_b_q, 2'h0};
        csr_pkg::REG_MULDIV:    rd_data_q <= muldiv_q;
        csr_pkg::REG_ARITH:     rd_data_q <= {20'h0_0000, df_q, v_q, n_q, z_q, c_q, bp_q, fc_q};
        csr_pkg::REG_BP_ALIAS:  rd_data_q <= {30'h0000_0000, bp_q};
        csr_pkg::REG_FC_ALIAS:  rd_data_q <= {27'h000_0000, fc_q};
        default:                rd_data_q <= csr_pkg::ZERO_WORD;
      endcase
    end
  end

  assign sr_rd_data       = rd_data_q;
  assign tag_match        = tag_match_q;
  assign a_reg_num        = a_num_q;
  assign b_reg_num        = b_num_q;
  assign c_reg_num        = c_num_q;
  assign reg_num_absolute = abs_q;
  assign muldiv_word      = muldiv_q;
  assign divide_add       = df_q;
  assign alu_carry_in     = c_q;
  assign ext_result       = ext_q;
  assign fsh_result       = fsh_q;
  assign byte_selector    = bp_q;
  assign shift_amount     = fc_q;

endmodule : csr_special_regs
